/* logic/ppfe_encoder.sv */
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Sample FIFO between converter capture and data store
module ppfe_fifo #(
    parameter int unsigned WIDTH = 11,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("ppfe_fifo: DEPTH must be a power of two of at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;

    // Honest full and empty from pointer comparison
    assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid = (wr_ptr != rd_ptr);
    assign out_data  = mem[rd_ptr[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule : ppfe_fifo

////////////////////////////////////////////////////////////////////////////////
// Pulse position frame encoder top
module ppfe_encoder import ppfe_pkg::*; #(
    parameter int unsigned FRAME_LEN = FRAME_CYCLES,
    parameter int unsigned CHANNELS  = NUM_CH
) (
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic [7:0] adc_data,
    output logic      [2:0] chan_sel,
    output logic            adc_start,
    output logic            pulse_out,
    output logic            encoder_on
);
    localparam int unsigned FW = $clog2(FRAME_LEN);
    localparam int unsigned TW = $clog2(TICK_CYCLES);
    localparam int unsigned PW = $clog2(PULSE_CYCLES + 1);

    initial begin
        if (CHANNELS < 1 || CHANNELS > 7 || FRAME_LEN < 2 * TICK_CYCLES) begin
            $error("ppfe_encoder: CHANNELS must be 1..7 and FRAME_LEN long enough");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and input synchronisers
    logic       rst_meta;
    logic       rst_n;
    logic [7:0] adc_meta;
    logic [7:0] adc_sync;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            adc_meta <= 8'h00;
            adc_sync <= 8'h00;
        end else begin
            adc_meta <= adc_data;
            adc_sync <= adc_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Free running frame timer
    logic [FW-1:0] frame_cnt;
    logic          frame_hit;

    assign frame_hit = (frame_cnt == FW'(FRAME_LEN - 1));

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_cnt <= FW'(FRAME_LEN - 1); // First frame opens at once after reset
        end else if (frame_hit) begin
            frame_cnt <= '0;
        end else begin
            frame_cnt <= frame_cnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state, step timer and data counter
    ppfe_state_t   state;
    logic [TW-1:0] tick;
    logic [8:0]    dcnt;
    logic [2:0]    sent;
    logic [7:0]    store;
    logic          step;
    logic          at_count;
    logic          match;
    logic          pulse_start;
    logic          stop_hit;

    assign step        = (state != PPFE_OFF) && (tick == TW'(TICK_CYCLES - 1));
    assign at_count    = (state == PPFE_SELECT) && (tick == '0);
    assign match       = (state == PPFE_ENCODE) && (tick == '0) && (dcnt[7:0] == store);
    assign pulse_start = frame_hit || match;
    assign stop_hit    = at_count && (dcnt == CNT_RESET) && (sent == 3'(CHANNELS));

    // State transitions
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= PPFE_OFF;
        end else if (frame_hit) begin
            state <= PPFE_SELECT;
        end else if (match) begin
            state <= PPFE_SELECT;
        end else if (stop_hit) begin
            state <= PPFE_OFF;
        end else if (state == PPFE_SELECT && step && dcnt == CNT_SELECT_END) begin
            state <= PPFE_ENCODE;
        end
    end

    // Step timer, one count per 4.4 us
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick <= '0;
        end else if (pulse_start || step || state == PPFE_OFF) begin
            tick <= '0;
        end else begin
            tick <= tick + 1'b1;
        end
    end

    // Data counter: preset at each reference, stopped while off
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dcnt <= CNT_PRESET;
        end else if (pulse_start) begin
            dcnt <= CNT_PRESET;
        end else if (stop_hit) begin
            dcnt <= CNT_PRESET;
        end else if (step && dcnt != 9'h1ff) begin
            dcnt <= dcnt + 9'h001;
        end
    end

    // Count of data pulses sent in this frame
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sent <= 3'h0;
        end else if (frame_hit) begin
            sent <= 3'h0;
        end else if (match) begin
            sent <= sent + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Programmer: channel advance and digitize command
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            chan_sel <= CHAN_INIT;
        end else if (frame_hit) begin
            chan_sel <= CHAN_INIT;
        end else if (at_count && dcnt == CNT_ADVANCE) begin
            chan_sel <= chan_sel + 3'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            adc_start <= 1'b0;
        end else begin
            adc_start <= at_count && (dcnt == CNT_DIGITIZE) && !frame_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Capture into FIFO, transfer into the data store
    ppfe_sample_t cap;
    ppfe_sample_t fifo_out;
    logic         cap_valid;
    logic         cap_ready;
    logic         fifo_valid;
    logic         xfer;

    assign cap.chan  = chan_sel;
    assign cap.value = adc_sync;
    assign cap_valid = at_count && (dcnt == CNT_SAMPLE) && !frame_hit;
    assign xfer      = at_count && (dcnt == CNT_TRANSFER) && !frame_hit;

    ppfe_fifo #(
        .WIDTH ($bits(ppfe_sample_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (cap_valid),
        .in_ready  (cap_ready),
        .in_data   (cap),
        .out_valid (fifo_valid),
        .out_ready (xfer),
        .out_data  (fifo_out)
    );

    // Store loads only at transfer, held through encode
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            store <= 8'h00;
        end else if (xfer && fifo_valid && (fifo_out.chan == chan_sel)) begin
            store <= fifo_out.value;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output pulse shaping and on/off flag
    logic [PW-1:0] pulse_cnt;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_cnt <= '0;
            pulse_out <= 1'b0;
        end else if (pulse_start) begin
            pulse_cnt <= PW'(PULSE_CYCLES - 1);
            pulse_out <= 1'b1;
        end else if (pulse_cnt != '0) begin
            pulse_cnt <= pulse_cnt - 1'b1;
        end else begin
            pulse_out <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            encoder_on <= 1'b0;
        end else begin
            encoder_on <= frame_hit || (encoder_on && !stop_hit);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence seq_match;
        (state == PPFE_ENCODE) && (tick == '0) && (dcnt[7:0] == store) && !frame_hit;
    endsequence

    sequence seq_restart;
        (state == PPFE_SELECT) && (dcnt == CNT_PRESET) && pulse_out;
    endsequence

    a_match_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
        seq_match |=> seq_restart)
        else $error("Equality did not give a data pulse and restart");

    a_store_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == PPFE_ENCODE) |=> $stable(store))
        else $error("Data store changed during encode");

    a_select_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == PPFE_SELECT) && step && (dcnt == CNT_SELECT_END) && !frame_hit
        |=> (state == PPFE_ENCODE) && (dcnt[7:0] == 8'h00) && (dcnt[8] == 1'b1))
        else $error("Select period did not hand over to encode at zero");

    a_off_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == PPFE_OFF) && !frame_hit |=> !$rose(pulse_out))
        else $error("Pulse emitted while encoder off");

    a_frame_open: assert property (@(posedge sys_clk) disable iff (!rst_n)
        frame_hit |=> (state == PPFE_SELECT) && (sent == 3'h0) && pulse_out && (frame_cnt == '0))
        else $error("Frame pulse did not open a frame");

    a_stop_last: assert property (@(posedge sys_clk) disable iff (!rst_n)
        stop_hit && !frame_hit |=> (state == PPFE_OFF) && !encoder_on)
        else $error("Encoder not stopped past last channel");

    a_adc_cmd: assert property (@(posedge sys_clk) disable iff (!rst_n)
        adc_start |-> ($past(dcnt) == CNT_DIGITIZE) && (state == PPFE_SELECT))
        else $error("Digitize command at wrong count");

    a_chan_adv: assert property (@(posedge sys_clk) disable iff (!rst_n)
        at_count && (dcnt == CNT_ADVANCE) && !frame_hit |=> chan_sel == $past(chan_sel) + 3'h1)
        else $error("Channel advance missing");

    a_one_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
        seq_match |=> !match [*8])
        else $error("Second data pulse in one channel");

    a_step_rate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == PPFE_SELECT) && step && !pulse_start && !stop_hit
        |=> (dcnt == $past(dcnt) + 9'h001) && (tick == '0))
        else $error("Data counter did not step once per tick");

    a_cap_room: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cap_valid |-> cap_ready)
        else $error("Sample arrived with capture queue full");

endmodule : ppfe_encoder

/* logic/ppfe_pkg.sv */
package ppfe_pkg;

    // Base timing
    localparam int unsigned CLK_NS        = 100;
    localparam int unsigned TICK_NS       = 4400;
    localparam int unsigned TICK_CYCLES   = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned FRAME_MS      = 20;
    localparam int unsigned FRAME_CYCLES  = FRAME_MS * 1000000 / CLK_NS;
    localparam int unsigned PULSE_NS      = 4400;
    localparam int unsigned PULSE_CYCLES  = (PULSE_NS + CLK_NS - 1) / CLK_NS;

    // Sequencer event times within a channel slot
    localparam int unsigned RESET_NS      = 237000;
    localparam int unsigned ADVANCE_NS    = 378000;
    localparam int unsigned DIGITIZE_NS   = 519000;
    localparam int unsigned ADC_CONV_NS   = 18000;
    localparam int unsigned TRANSFER_NS   = 659000;

    // Data counter values
    localparam logic [8:0] CNT_PRESET     = 9'h02a;
    localparam logic [8:0] CNT_SELECT_END = 9'h0ff;
    localparam logic [8:0] CNT_RESET      = CNT_PRESET + 9'((RESET_NS + TICK_NS / 2) / TICK_NS);
    localparam logic [8:0] CNT_ADVANCE    = CNT_PRESET + 9'((ADVANCE_NS + TICK_NS / 2) / TICK_NS);
    localparam logic [8:0] CNT_DIGITIZE   = CNT_PRESET + 9'((DIGITIZE_NS + TICK_NS / 2) / TICK_NS);
    localparam logic [8:0] CNT_SAMPLE     = CNT_PRESET + 9'((DIGITIZE_NS + ADC_CONV_NS + TICK_NS - 1) / TICK_NS);
    localparam logic [8:0] CNT_TRANSFER   = CNT_PRESET + 9'((TRANSFER_NS + TICK_NS / 2) / TICK_NS);

    // Channel plan
    localparam int unsigned NUM_CH        = 6;
    localparam logic [2:0]  CHAN_INIT     = 3'h7;
    localparam int unsigned FIFO_DEPTH    = 8;

    // Sequencer states
    typedef enum logic [1:0] {
        PPFE_OFF    = 2'b00,
        PPFE_SELECT = 2'b01,
        PPFE_ENCODE = 2'b10
    } ppfe_state_t;

    // Converted sample with its channel address
    typedef struct packed {
        logic [2:0] chan;
        logic [7:0] value;
    } ppfe_sample_t;

endpackage : ppfe_pkg

/* sim/ppfe_adc_model.sv */
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Behavioural multiplexer and converter on the analog side
module ppfe_adc_model #(
    parameter int unsigned CONV_CYC = 180,
    parameter int unsigned HOLD_CYC = 120
) (
    input  wire logic        sys_clk,
    input  wire logic [2:0]  chan_sel,
    input  wire logic        adc_start,
    input  wire logic [47:0] ch_vals,
    output logic      [7:0]  adc_data
);
    int unsigned age  = 1000;
    logic [7:0]  last = 8'h00;
    logic [7:0]  pick;

    // Code of the selected input, zero code for -10 V or an unused address
    assign pick = (chan_sel < 3'h6) ? ch_vals[{chan_sel, 3'b000} +: 8] : 8'h00;

    initial adc_data = 8'h00;

    // Result valid only inside its window, inverted value outside it
    always @(posedge sys_clk) begin
        if (adc_start === 1'b1) begin
            age <= 0;
        end else if (age < 1000) begin
            age <= age + 1;
        end
        if (age >= CONV_CYC && age < CONV_CYC + HOLD_CYC) begin
            adc_data <= pick;
            last     <= pick;
        end else begin
            adc_data <= ~last; // Stale data must not pass as a sample
        end
    end
endmodule : ppfe_adc_model

/* sim/tb_top.sv */
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the pulse position frame encoder
module tb_top;
    import ppfe_pkg::*;
    localparam int unsigned FLEN = 60000;
    localparam int unsigned STEP = 44;
    localparam int unsigned TMO  = 110000;

    logic        sys_clk;
    logic        rstn;
    logic [7:0]  adc_data;
    logic [2:0]  chan_sel;
    logic        adc_start;
    logic        pulse_out;
    logic        encoder_on;
    logic [47:0] ch_vals;
    logic        p_pulse = 1'b0;
    logic        p_on    = 1'b0;
    logic [2:0]  p_sel   = 3'h7;
    logic [2:0]  sel_adc = 3'h0;
    int          n_mismatch      = 0;
    int          samples_checked = 0;
    int          cyc    = 0;
    int          seed   = 63;
    int          hi_cnt = 0;
    int          last_width = 0;
    int          t_sel  = 0;
    int          t_adc  = 0;
    int          t_off  = 0;

    ppfe_encoder #(.FRAME_LEN(FLEN), .CHANNELS(6)) i_ppfe_encoder (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .adc_data   (adc_data),
        .chan_sel   (chan_sel),
        .adc_start  (adc_start),
        .pulse_out  (pulse_out),
        .encoder_on (encoder_on)
    );

    ppfe_adc_model i_ppfe_adc_model (
        .sys_clk   (sys_clk),
        .chan_sel  (chan_sel),
        .adc_start (adc_start),
        .ch_vals   (ch_vals),
        .adc_data  (adc_data)
    );

    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Event stamps, pulse width and hang guard
    always @(posedge sys_clk) begin
        cyc     <= cyc + 1;
        p_pulse <= pulse_out;
        p_on    <= encoder_on;
        p_sel   <= chan_sel;
        if (pulse_out === 1'b1) hi_cnt <= hi_cnt + 1;
        if (pulse_out === 1'b0 && p_pulse === 1'b1) begin
            last_width <= hi_cnt;
            hi_cnt     <= 0;
        end
        if (chan_sel !== p_sel) t_sel <= cyc;
        if (adc_start === 1'b1) begin
            t_adc   <= cyc;
            sel_adc <= chan_sel;
        end
        if (encoder_on === 1'b0 && p_on === 1'b1) t_off <= cyc;
        if (cyc == TMO) begin
            n_mismatch = n_mismatch + 1;
            $display("timeout at cycle %0d", cyc);
            end_sim();
        end
    end

    // Gap from one pulse to the next for a channel code
    function automatic int exp_gap(input logic [7:0] v);
        return (int'(CNT_SELECT_END) + 1 - int'(CNT_PRESET) + int'(v)) * STEP + 1; // One cycle compare to pulse
    endfunction : exp_gap

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value %s expected %0d seen %0d", name, exp, seen);
        end
    endtask : check

    task automatic wait_rise(output int t);
        @(posedge sys_clk);
        while (!(pulse_out === 1'b1 && p_pulse === 1'b0)) @(posedge sys_clk);
        t = cyc;
    endtask : wait_rise

    // Frame pulse, then one data pulse per channel
    task automatic run_frame(input int n_ch, input logic [47:0] vals, output int t_f, output int t_l);
        int t1;
        wait_rise(t_f);
        t_l = t_f;
        repeat (2) @(posedge sys_clk);
        check("encoder_on at frame", encoder_on, 1);
        for (int k = 0; k < n_ch; k++) begin
            wait_rise(t1);
            check("pulse gap", t1 - t_l, exp_gap(vals[k*8 +: 8]));
            check("channel at digitize", sel_adc, k);
            check("advance time", t_sel - t_l, 86 * STEP + 1);
            check("digitize time", t_adc - t_l, 118 * STEP + 1);
            check("pulse width", last_width, PULSE_CYCLES);
            t_l = t1;
        end
    endtask : run_frame

    task automatic end_sim();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    // Main sequence
    initial begin
        logic [47:0] v1;
        logic [47:0] v2;
        int tf1;
        int tl1;
        int tf2;
        int tl2;
        rstn    <= 1'b0;
        ch_vals <= 48'h0;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        // Full frame with zero code first and small random codes after
        v1 = 48'h0;
        for (int k = 1; k < 6; k++) v1[k*8 +: 8] = 8'($unsigned($random(seed)) % 5);
        ch_vals <= v1;
        run_frame(6, v1, tf1, tl1);
        repeat (55 * STEP) @(posedge sys_clk);
        check("stop after last channel", t_off - tl1, 54 * STEP + 1);
        check("encoder_on idle", encoder_on, 0);
        $display("test full frame done");
        // Next frame: full scale code, then a random code
        v2 = 48'h0;
        v2[7:0]  = 8'hff;
        v2[15:8] = 8'($random(seed));
        ch_vals <= v2;
        run_frame(2, v2, tf2, tl2);
        check("frame period", tf2 - tf1, FLEN);
        $display("test full scale frame done");
        end_sim();
    end
endmodule : tb_top
